// ===== src/fpk_pkg.sv
// shared constants and types for the front panel keypad block
package fpk_pkg;
   // clock rate and press timing
   localparam int CLK_HZ = 100_000_000;
   localparam int ACT_MS = 200;
   localparam int LONG_MS = 300;
   localparam int ACT_CYC = (ACT_MS * (CLK_HZ / 1000));
   localparam int LONG_CYC = (LONG_MS * (CLK_HZ / 1000));
   localparam int CNT_W = 26;
   // key indices
   localparam int KEY_N = 6;
   localparam int K_WP = 0;
   localparam int K_RL = 1;
   localparam int K_AM = 2;
   localparam int K_SEL = 3;
   localparam int K_MENU = 4;
   localparam int K_ACK = 5;
   // bargraph and text geometry
   localparam int BAR_SEGS = 50;
   localparam int BAR_N = 3;
   localparam int BAR_MEAS = 0;
   localparam int BAR_OUT = 2;
   localparam int TXT_CHARS = 9;
   localparam int VAR_N = 3;
   localparam int EXTRA_N = 3;
   // register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CFG = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_IRQ = 4'h3;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_BAR0 = 4'h5;
   localparam logic [3:0] REG_TXT0 = 4'h8;
   localparam logic [3:0] REG_TXT_LAST = 4'h9;
   // config bits
   localparam int CFG_WP_EN = 0;
   localparam int CFG_WS_PRIO = 1;
   localparam int CFG_WP_GATE = 2;
   localparam int CFG_RL_EN = 3;
   localparam int CFG_RL_GATE = 4;
   localparam int CFG_AM_GATE = 5;
   localparam int CFG_EXTRA = 6;
   localparam int CFG_FP2 = 7;
   localparam int CFG_NORMAL = 8;
   localparam logic [8:0] CFG_RST = 9'h100;
   // interrupt bits
   localparam int IRQ_W = 6;
   localparam int EV_MODE = 0;
   localparam int EV_SEL = 1;
   localparam int EV_FACE = 2;
   localparam int EV_MENU = 3;
   localparam int EV_ACK = 4;
   localparam int EV_TOO_SHORT = 5;
   // press state per key
   typedef enum logic [1:0] {
      PR_IDLE = 2'b00,
      PR_HELD = 2'b01,
      PR_ACT = 2'b11,
      PR_LONG = 2'b10
   } fpk_press_type;
endpackage

// ===== src/fpk_key_if.sv
// interface carrying one key's timed press events
`timescale 1ns/1ps
interface fpk_key_if;
   logic act;   // pulse: actuation threshold reached
   logic long_p;   // pulse: long threshold reached
   logic rel_short;   // pulse: released between the two thresholds
   logic glitch;   // pulse: released before actuation
   modport timer (output act, output long_p, output rel_short, output glitch);
   modport user (input act, input long_p, input rel_short, input glitch);
endinterface

// ===== src/fpk_key_timer.sv
// press timer for one key contact
`timescale 1ns/1ps
module fpk_key_timer
   import fpk_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // contact, high while closed
   input wire logic closed_i,
   // timed events
   fpk_key_if.timer ev
);
   fpk_press_type state;
   logic [CNT_W-1:0] cnt;   // cycles the contact has been closed

   // hold counter, saturates at the long threshold
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !closed_i) begin
         cnt <= '0;
      end else if (cnt != CNT_W'(LONG_CYC)) begin
         cnt <= cnt + 1'b1;
      end
   end

   // press phase; one act per closure so holding cannot repeat
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= PR_IDLE;
      end else begin
         case (state)
            PR_IDLE: if (closed_i) state <= PR_HELD;
            PR_HELD: begin
               if (!closed_i) state <= PR_IDLE;
               else if (cnt == CNT_W'(ACT_CYC - 1)) state <= PR_ACT;
            end
            PR_ACT: begin
               if (!closed_i) state <= PR_IDLE;
               else if (cnt == CNT_W'(LONG_CYC - 1)) state <= PR_LONG;
            end
            PR_LONG: if (!closed_i) state <= PR_IDLE;
            default: state <= PR_IDLE;
         endcase
      end
   end

   assign ev.act = (state == PR_HELD) && closed_i && (cnt == CNT_W'(ACT_CYC - 1));
   assign ev.long_p = (state == PR_ACT) && closed_i && (cnt == CNT_W'(LONG_CYC - 1));
   assign ev.rel_short = (state == PR_ACT) && !closed_i;
   assign ev.glitch = (state == PR_HELD) && !closed_i;
endmodule

// ===== src/fpk_panel.sv
// front panel keypad and display control top
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module fpk_panel
   import fpk_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // key contacts, high while closed
   input wire logic [KEY_N-1:0] key_closed_i,
   // alarm condition from detection logic
   input wire logic alarm_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // mode outputs
   output logic workstation_o,
   output logic remote_sp_o,
   output logic manual_o,
   output logic faceplate2_o,
   output logic menu_o,
   output logic alarm_on_o,
   output logic alarm_flash_o,
   // display drive
   output logic [BAR_SEGS+1:0] bar0_o,
   output logic [BAR_SEGS+1:0] bar1_o,
   output logic [BAR_SEGS+1:0] bar2_o,
   output logic [1:0] dot_o,
   output logic [2:0] sel_index_o,
   output logic [8*TXT_CHARS-1:0] line0_o,
   output logic [8*TXT_CHARS-1:0] line1_o,
   // interrupt
   output logic irq_o
);
   logic [8:0] cfg;   // configuration bits
   logic [IRQ_W-1:0] irq_stat;   // sticky events
   logic [IRQ_W-1:0] irq_mask;   // event enables
   logic [IRQ_W-1:0] ev;   // events this cycle
   logic [KEY_N-1:0] k_act, k_long, k_short, k_glitch;
   logic [5:0] bar_level [BAR_N];   // lit segments, 0..50
   logic [1:0] bar_ovr [BAR_N];   // bit1 above, bit0 below
   logic [7:0] txt [2*TXT_CHARS];   // character memory
   logic alarm_acked;   // operator saw the alarm
   logic menu_exit;   // software leaves the menu
   logic sel_step;   // advance selection this cycle
   logic face_tog;   // swap faceplates this cycle
   logic [2:0] sel_limit;   // entries in the select cycle
   logic [2:0] next_sel;

   // one timer per key
   for (genvar g = 0; g < KEY_N; g++) begin : g_key
      fpk_key_if kif ();
      fpk_key_timer u_tmr (
         .sys_clk_i(sys_clk_i),
         .rst_i(rst_i),
         .closed_i(key_closed_i[g]),
         .ev(kif.timer)
      );
      assign k_act[g] = kif.act;
      assign k_long[g] = kif.long_p;
      assign k_short[g] = kif.rel_short;
      assign k_glitch[g] = kif.glitch;
   end

   // one faceplate makes long a short
   assign face_tog = k_long[K_SEL] && cfg[CFG_FP2];
   // short release or unpaired long advances
   assign sel_step = k_short[K_SEL] || (k_long[K_SEL] && !cfg[CFG_FP2]);
   assign sel_limit = cfg[CFG_EXTRA] ? 3'(VAR_N + EXTRA_N) : 3'(VAR_N);
   assign next_sel = (sel_index_o + 3'h1 >= sel_limit) ? 3'h0 : sel_index_o + 3'h1;

   // configuration register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cfg <= CFG_RST;
      end else if (reg_wr_i && reg_addr_i == REG_CFG) begin
         cfg <= reg_wdata_i[8:0];
      end
   end

   // workstation / panel mode
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         workstation_o <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
         workstation_o <= reg_wdata_i[0];
      end else if (k_act[K_WP] && cfg[CFG_WP_EN] && !cfg[CFG_WS_PRIO] && !cfg[CFG_WP_GATE]) begin
         workstation_o <= !workstation_o;
      end
   end

   // remote / local set point
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         remote_sp_o <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
         remote_sp_o <= reg_wdata_i[1];
      end else if (k_act[K_RL] && cfg[CFG_RL_EN] && !workstation_o && !cfg[CFG_RL_GATE]) begin
         remote_sp_o <= !remote_sp_o;
      end
   end

   // auto / manual
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         manual_o <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
         manual_o <= reg_wdata_i[2];
      end else if (k_act[K_AM] && !workstation_o && !cfg[CFG_AM_GATE]) begin
         manual_o <= !manual_o;
      end
   end

   // faceplate select
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         faceplate2_o <= 1'b0;
      end else if (!cfg[CFG_FP2]) begin
         faceplate2_o <= 1'b0;
      end else if (face_tog) begin
         faceplate2_o <= !faceplate2_o;
      end
   end

   // lower display selection and bargraph dot
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sel_index_o <= 3'h0;
      end else if (k_act[K_AM] && !workstation_o && !cfg[CFG_AM_GATE]) begin
         sel_index_o <= manual_o ? 3'(BAR_MEAS) : 3'(BAR_OUT);
      end else if (sel_step) begin
         sel_index_o <= next_sel;
      end
   end
   // entries beyond the bars leave the dot on no bar
   assign dot_o = (sel_index_o < 3'(BAR_N)) ? sel_index_o[1:0] : 2'h3;

   // menu entry; software ends it
   assign menu_exit = reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[3];
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         menu_o <= 1'b0;
      end else if (k_act[K_MENU] && !workstation_o) begin
         menu_o <= 1'b1;
      end else if (menu_exit) begin
         menu_o <= 1'b0;
      end
   end

   // alarm indicator: flashing until acknowledged
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !alarm_i) begin
         alarm_acked <= 1'b0;
      // acknowledge in normal mode, either W or P
      end else if (k_act[K_ACK] && cfg[CFG_NORMAL] && !menu_o) begin
         alarm_acked <= 1'b1;
      end
   end
   assign alarm_on_o = alarm_i;
   assign alarm_flash_o = alarm_i && !alarm_acked;

   // bargraph levels from software, clamped to full scale
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < BAR_N; i++) begin
            bar_level[i] <= 6'h00;
            bar_ovr[i] <= 2'h0;
         end
      end else begin
         for (int i = 0; i < BAR_N; i++) begin
            if (reg_wr_i && reg_addr_i == REG_BAR0 + 4'(i)) begin
               bar_level[i] <= (reg_wdata_i[5:0] > 6'(BAR_SEGS)) ? 6'(BAR_SEGS) : reg_wdata_i[5:0];
               bar_ovr[i] <= reg_wdata_i[9:8];
            end
         end
      end
   end

   // segments as thermometer, pointers on top and bottom
   function automatic logic [BAR_SEGS+1:0] bar_map(input logic [5:0] lvl, input logic [1:0] ovr);
      logic [BAR_SEGS+1:0] m;
      m = '0;
      for (int s = 0; s < BAR_SEGS; s++) begin
         m[s+1] = (6'(s) < lvl);
      end
      m[BAR_SEGS+1] = ovr[1];
      m[0] = ovr[0];
      return m;
   endfunction
   assign bar0_o = bar_map(bar_level[0], bar_ovr[0]);
   assign bar1_o = bar_map(bar_level[1], bar_ovr[1]);
   assign bar2_o = bar_map(bar_level[2], bar_ovr[2]);

   // two lines of nine characters, written one word per char
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < 2*TXT_CHARS; c++) begin
            txt[c] <= 8'h20;
         end
      end else if (reg_wr_i && reg_addr_i >= REG_TXT0 && reg_addr_i <= REG_TXT_LAST) begin
         // each word carries a character index and code
         if (reg_wdata_i[12:8] < 5'(2*TXT_CHARS)) begin
            txt[reg_wdata_i[12:8]] <= reg_wdata_i[7:0];
         end
      end
   end
   always_comb begin
      for (int c = 0; c < TXT_CHARS; c++) begin
         line0_o[8*c +: 8] = txt[c];
         line1_o[8*c +: 8] = txt[TXT_CHARS + c];
      end
   end

   // events for the interrupt status
   always_comb begin
      ev = '0;
      ev[EV_MODE] = k_act[K_WP] || k_act[K_RL] || k_act[K_AM];
      ev[EV_SEL] = sel_step;
      ev[EV_FACE] = face_tog;
      ev[EV_MENU] = k_act[K_MENU] && !workstation_o;
      ev[EV_ACK] = k_act[K_ACK];
      ev[EV_TOO_SHORT] = |k_glitch;
   end

   // sticky status, write one to clear; a new event wins over a clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_stat <= '0;
      end else if (reg_wr_i && reg_addr_i == REG_IRQ) begin
         irq_stat <= (irq_stat & ~reg_wdata_i[IRQ_W-1:0]) | ev;
      end else begin
         irq_stat <= irq_stat | ev;
      end
   end

   // interrupt mask
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_mask <= '0;
      end else if (reg_wr_i && reg_addr_i == REG_MASK) begin
         irq_mask <= reg_wdata_i[IRQ_W-1:0];
      end
   end
   assign irq_o = |(irq_stat & irq_mask);

   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= 32'h0;
      end else begin
         case (reg_addr_i)
            REG_CTRL: reg_rdata_o <= {28'h0, menu_o, manual_o, remote_sp_o, workstation_o};
            REG_CFG: reg_rdata_o <= {23'h0, cfg};
            REG_STATUS: reg_rdata_o <= {24'h0, faceplate2_o, alarm_flash_o, alarm_i, 2'h0, sel_index_o};
            REG_IRQ: reg_rdata_o <= {26'h0, irq_stat};
            REG_MASK: reg_rdata_o <= {26'h0, irq_mask};
            default: reg_rdata_o <= 32'h0;
         endcase
      end
   end
endmodule

// ===== verification/fpk_panel_checker.sv
// assertion checker for the front panel keypad block
`timescale 1ns/1ps
module fpk_panel_checker
   import fpk_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // watched inputs
   input wire logic [KEY_N-1:0] key_closed_i,
   input wire logic alarm_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   // watched outputs
   input wire logic [31:0] reg_rdata_o,
   input wire logic workstation_o,
   input wire logic remote_sp_o,
   input wire logic manual_o,
   input wire logic menu_o,
   input wire logic alarm_on_o,
   input wire logic alarm_flash_o,
   input wire logic [1:0] dot_o,
   input wire logic irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // software write to the mode register
   logic wr_ctrl;
   // mode bits carried by that write
   logic [2:0] ctrl_w;
   // closed cycles of the auto/manual key
   logic [CNT_W-1:0] am_cnt;
   assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
   assign ctrl_w = reg_wdata_i[2:0];
   // saturate so a stuck key never wraps back under the threshold
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !key_closed_i[K_AM]) begin
         am_cnt <= '0;
      end else if (am_cnt != '1) begin
         am_cnt <= am_cnt + 1'b1;
      end
   end
   AST_ACT_MIN: assert property ($changed(manual_o) && !$past(wr_ctrl) |-> $past(am_cnt) >= ACT_CYC - 2)
      else $error("auto/manual changed before actuation time");
   AST_NO_REPEAT: assert property (am_cnt > ACT_CYC && !wr_ctrl |=> $stable(manual_o))
      else $error("held key toggled again");
   AST_AM_LOCK: assert property (workstation_o && !wr_ctrl |=> $stable(manual_o))
      else $error("auto/manual moved in workstation mode");
   AST_RL_LOCK: assert property (workstation_o && !wr_ctrl |=> $stable(remote_sp_o))
      else $error("remote/local moved in workstation mode");
   AST_MENU_LOCK: assert property (workstation_o && !menu_o |=> !menu_o)
      else $error("menu entered in workstation mode");
   AST_DOT_OUT: assert property ($rose(manual_o) && !$past(wr_ctrl) |-> ##[0:1] dot_o == BAR_OUT)
      else $error("dot not on output bar after manual");
   AST_FLASH: assert property (!alarm_i |-> !alarm_flash_o && !alarm_on_o)
      else $error("alarm indicator lit without alarm");
   AST_CTRL_WR: assert property (wr_ctrl |=> {manual_o, remote_sp_o, workstation_o} == $past(ctrl_w))
      else $error("mode write not applied");
   AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside read cycle");
   AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > REG_TXT_LAST |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_IRQ_MASK: assert property (reg_wr_i && reg_addr_i == REG_MASK && reg_wdata_i[IRQ_W-1:0] == '0 |=> !irq_o)
      else $error("interrupt high with all masked");
endmodule
bind fpk_panel fpk_panel_checker u_chk (.sys_clk_i, .rst_i, .key_closed_i, .alarm_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .workstation_o, .remote_sp_o, .manual_o,
   .menu_o, .alarm_on_o, .alarm_flash_o, .dot_o, .irq_o);

// ===== verification/fpk_operator.sv
// operator model pressing the panel keys
`timescale 1ns/1ps
module fpk_operator
   import fpk_pkg::*;
(
   // clock
   input wire logic sys_clk_i,
   // contacts, high while a key is held
   output logic [KEY_N-1:0] keys_o
);
   // all keys open until a press is asked for
   initial begin
      keys_o = '0;
   end
   // hold one key for a number of cycles, then let go
   task automatic press(input int key, input int cycles);
      @(posedge sys_clk_i);
      keys_o[key] <= 1'b1;
      repeat (cycles) @(posedge sys_clk_i);
      keys_o[key] <= 1'b0;
   endtask
endmodule

// ===== verification/tb.sv
// self-checking bench for the front panel keypad block
`timescale 1ns/1ps
module tb;
   import fpk_pkg::*;
   // clock, reset and register port
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic alarm_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   // contacts from the operator and design outputs
   logic [KEY_N-1:0] key_closed_i;
   logic [31:0] reg_rdata_o;
   logic workstation_o, remote_sp_o, manual_o, faceplate2_o, menu_o, alarm_on_o, alarm_flash_o, irq_o;
   logic [BAR_SEGS+1:0] bar_o [BAR_N];
   logic [1:0] dot_o;
   logic [2:0] sel_index_o;
   logic [8*TXT_CHARS-1:0] line0_o, line1_o;
   // bookkeeping
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [71:0] blank = {9{8'h20}};
   always #5 sys_clk_i = ~sys_clk_i;
   fpk_panel u_dut (.sys_clk_i, .rst_i, .key_closed_i, .alarm_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .workstation_o, .remote_sp_o, .manual_o, .faceplate2_o,
      .menu_o, .alarm_on_o, .alarm_flash_o, .bar0_o(bar_o[0]), .bar1_o(bar_o[1]), .bar2_o(bar_o[2]),
      .dot_o, .sel_index_o, .line0_o, .line1_o, .irq_o);
   fpk_operator u_op (.sys_clk_i, .keys_o(key_closed_i));
   // hang guard, several times the planned run
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors = num_errors + 1;
         test_done();
      end
   end
   // compare and count
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle write, then let the effect land
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   // one-cycle read; data only stand in the following cycle
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(72'(reg_rdata_o), 72'(exp));
   endtask
   // thermometer image: bottom pointer, segments, top pointer
   function automatic logic [BAR_SEGS+1:0] bar_exp(input int lvl, input logic up, input logic dn);
      logic [BAR_SEGS+1:0] v;
      v = '0;
      for (int s = 1; s <= BAR_SEGS; s++) v[s] = (s <= lvl);
      v[BAR_SEGS+1] = up;
      v[0] = dn;
      return v;
   endfunction
   // verdict in one place
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(REG_CTRL, 32'h0);
      rd(REG_CFG, 32'(CFG_RST));
      chk(line1_o, blank); // spaces after reset
      // every bar: mid level, clamp with both pointers, empty above range
      for (int b = 0; b < BAR_N; b++) begin
         wr(REG_BAR0 + 4'(b), 32'd25);
         chk(72'(bar_o[b]), 72'(bar_exp(25, 1'b0, 1'b0))); // half scale
         wr(REG_BAR0 + 4'(b), 32'h33f);
         chk(72'(bar_o[b]), 72'(bar_exp(50, 1'b1, 1'b1))); // clamp
         wr(REG_BAR0 + 4'(b), 32'h200);
         chk(72'(bar_o[b]), 72'(bar_exp(0, 1'b1, 1'b0))); // top pointer
      end
      // first and last character, then an index past the end
      wr(REG_TXT0, 32'h0041);
      wr(REG_TXT0, 32'h115a);
      wr(REG_TXT0, 32'h1230);
      chk(line0_o, {blank[71:8], 8'h41}); // first char
      chk(line1_o, {8'h5a, blank[63:0]}); // last char
      wr(REG_CTRL, 32'h7);
      rd(REG_CTRL, 32'h7); // workstation, remote and manual set
      // every key released well before actuation
      for (int k = 0; k < KEY_N; k++) u_op.press(k, 1000);
      repeat (3) @(posedge sys_clk_i);
      chk(72'({workstation_o, remote_sp_o, manual_o, menu_o, faceplate2_o}), 72'h1c); // no action
      chk(72'(sel_index_o), 72'h0); // no step
      chk(72'(dot_o), 72'h0); // dot stays on first bar
      rd(REG_IRQ, 32'h20); // too-short press event
      chk(72'(irq_o), 72'h0);
      wr(REG_MASK, 32'h20);
      chk(72'(irq_o), 72'h1);
      wr(REG_MASK, 32'h0);
      chk(72'(irq_o), 72'h0);
      wr(REG_MASK, 32'h20);
      wr(REG_IRQ, 32'h20);
      chk(72'(irq_o), 72'h0);
      rd(REG_IRQ, 32'h0);
      // alarm flashes until acknowledged; a brushed key does not count
      @(posedge sys_clk_i);
      alarm_i <= 1'b1;
      u_op.press(K_ACK, 500);
      repeat (2) @(posedge sys_clk_i);
      chk(72'({alarm_on_o, alarm_flash_o}), 72'h3); // still flashing
      rd(REG_STATUS, 32'h60); // alarm and flash
      @(posedge sys_clk_i);
      alarm_i <= 1'b0;
      rd(4'hf, 32'h0);
      wr(4'hf, 32'hffff_ffff);
      rd(REG_CTRL, 32'h7); // unmapped write ignored
      wr(REG_CFG, 32'h0ff);
      rd(REG_CFG, 32'h0ff);
      // second reset in mid-run
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      #1 chk(72'({workstation_o, remote_sp_o, manual_o, alarm_flash_o}), 72'h0); // cleared
      chk(line0_o, blank); // spaces again
      test_done();
   end
endmodule
